//--- verilog/tdl_cfg.svh
// constants for the test access port and debug link block
`ifndef TDL_CFG_SVH
`define TDL_CFG_SVH

// instruction register and data register widths
`define TDL_IR_W 3
`define TDL_DBG_W 10
`define TDL_PRG_W 3
`define TDL_STAT_W 2
`define TDL_BYTE_W 8

// instruction codes
`define TDL_IR_EXTEST 3'h0
`define TDL_IR_SAMPLE 3'h1
`define TDL_IR_DEBUG 3'h2
`define TDL_IR_BYPASS 3'h3
`define TDL_IR_PROG 3'h4
`define TDL_IR_RSVD 3'h6
`define TDL_IR_CAPTURE 3'h1

// register map, byte addresses
`define TDL_AXI_AW 8
`define TDL_OFS_STAT 8'h00
`define TDL_OFS_HOLD 8'h04
`define TDL_OFS_TAP 8'h08

// field positions in the tap status register
`define TDL_TAP_STATE_LSB 0
`define TDL_TAP_INSTR_LSB 4
`define TDL_TAP_RXF_BIT 7
`define TDL_TAP_PRG_LSB 8
`define TDL_TAP_SEL_LSB 12

// reset values
`define TDL_RST_STAT 2'h0
`define TDL_RST_HOLD 8'h00

// bus responses
`define TDL_RESP_OKAY 2'h0
`define TDL_RESP_SLVERR 2'h2

`endif

//--- verilog/tdl_pkg.sv
// types for the test access port and debug link block
package tdl_pkg;
`include "tdl_cfg.svh"

   // controller states
   typedef enum logic [3:0] {
      TAP_TLR = 4'b0000,
      TAP_RTI = 4'b0001,
      TAP_SEL_DR = 4'b0010,
      TAP_CAP_DR = 4'b0011,
      TAP_SH_DR = 4'b0100,
      TAP_EX1_DR = 4'b0101,
      TAP_PA_DR = 4'b0110,
      TAP_EX2_DR = 4'b0111,
      TAP_UPD_DR = 4'b1000,
      TAP_SEL_IR = 4'b1001,
      TAP_CAP_IR = 4'b1010,
      TAP_SH_IR = 4'b1011,
      TAP_EX1_IR = 4'b1100,
      TAP_PA_IR = 4'b1101,
      TAP_EX2_IR = 4'b1110,
      TAP_UPD_IR = 4'b1111
   } tdl_tap_t;

   // serial data path selection
   typedef enum logic [1:0] {
      SEL_BYP = 2'b00,
      SEL_DBG = 2'b01,
      SEL_PRG = 2'b10
   } tdl_sel_t;

   // whole state of the block
   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic tck_q;
      logic [2:0] tms_run;
      tdl_tap_t tap;
      logic [`TDL_IR_W-1:0] ir_shift;
      logic [`TDL_IR_W-1:0] instr_parallel_reg;
      tdl_sel_t sel;
      logic byp;
      logic [`TDL_DBG_W-1:0] dsr;
      logic [`TDL_PRG_W-1:0] psr;
      logic [`TDL_PRG_W-1:0] prg_par;
      logic [`TDL_BYTE_W-1:0] debug_holding_byte;
      logic [`TDL_STAT_W-1:0] debug_status_pair;
      logic rx_flag;
      logic tdo;
      logic tdo_oe;
      logic aw_got;
      logic w_got;
      logic [`TDL_AXI_AW-1:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } tdl_state_t;
endpackage

//--- verilog/tdl_top.sv
// test access port controller with debug link and register slave
// Notes on behaviour
// - codes 000 and 001 are latched as the instruction but keep the previous data path
// - codes 011, 101 and 111 select the one-bit bypass cell
// - in reset state the parallel instruction is forced to bypass
// - debug code 010 selects the ten-bit shift register
// - programming code 100 selects the three-bit shift register
// - code 110 is reserved; host must not load it
// - shift-dr moves selected register one place per test clock
// - update-dr falling edge copies shift register into parallel buffer
// - same edge reloads the shift register from the parallel buffer
// - data scans never touch either instruction register
// - with test clock low, state and scan registers hold
// - after reset: reset state, bypass instruction, bypass path
// - mode select high at a rising edge keeps reset state
// - private instruction takes effect when latched in update-ir
// - instruction kept until new scan or reset state
// - debug word is ten bits: two status bits and a byte
// - debug word shifts least significant bit first
// - status pair: 00 inactive, 01 idle, 10 busy, 11 valid
// - update-dr latches incoming byte and loads outgoing byte
// - capture-ir loads 001 into the instruction shift register
// - update-ir falling edge moves shift into parallel instruction
// - five rising edges with mode select high reach reset state
// - serial input is sampled at the rising test clock edge
`timescale 1ns/100ps
`include "tdl_cfg.svh"
module tdl_top
   import tdl_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   input wire logic TCK_I,
   input wire logic TMS_I,
   input wire logic TDI_I,
   output logic TDO_O,
   output logic TDO_OE_O,
   input wire logic [`TDL_AXI_AW-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [`TDL_AXI_AW-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I
);

   tdl_state_t r_reg;
   tdl_state_t r_next;
   logic tck_rise;
   logic tck_fall;
   logic tms_s;
   logic tdi_s;

   // controller transitions on a sampled mode select
   function automatic tdl_tap_t tap_step(input tdl_tap_t s, input logic m);
      tdl_tap_t n;
      begin
         n = s;
         unique case (s)
            TAP_TLR: n = m ? TAP_TLR : TAP_RTI;
            TAP_RTI: n = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: n = m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR: n = m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: n = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: n = m ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: n = m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR: n = m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: n = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_RTI;
         endcase
         return n;
      end
   endfunction

   // data path chosen by a freshly latched instruction
   function automatic tdl_sel_t sel_decode(input logic [2:0] c,
                                           input tdl_sel_t old);
      tdl_sel_t n;
      begin
         n = SEL_BYP; // bypass codes and reserved code
         if (c == `TDL_IR_EXTEST || c == `TDL_IR_SAMPLE)
         begin
            n = old; // no-operation keeps the path
         end
         else if (c == `TDL_IR_DEBUG)
         begin
            n = SEL_DBG;
         end
         else if (c == `TDL_IR_PROG)
         begin
            n = SEL_PRG;
         end
         return n;
      end
   endfunction

   // register read decode
   function automatic logic [31:0] reg_read(input tdl_state_t s,
                                            input logic [7:0] a);
      logic [31:0] d;
      begin
         d = 32'h00000000;
         if (a == `TDL_OFS_STAT)
         begin
            d[1:0] = s.debug_status_pair;
         end
         else if (a == `TDL_OFS_HOLD)
         begin
            d[7:0] = s.debug_holding_byte;
         end
         else if (a == `TDL_OFS_TAP)
         begin
            d[`TDL_TAP_STATE_LSB+:4] = s.tap;
            d[`TDL_TAP_INSTR_LSB+:3] = s.instr_parallel_reg;
            d[`TDL_TAP_RXF_BIT] = s.rx_flag;
            d[`TDL_TAP_PRG_LSB+:3] = s.prg_par;
            d[`TDL_TAP_SEL_LSB+:2] = s.sel;
         end
         return d;
      end
   endfunction

   function automatic logic addr_ok(input logic [7:0] a);
      return a == `TDL_OFS_STAT || a == `TDL_OFS_HOLD ||
             a == `TDL_OFS_TAP;
   endfunction

   // test clock edges and pin levels after the synchroniser
   assign tck_rise = r_reg.sync2[2] & ~r_reg.tck_q;
   assign tck_fall = ~r_reg.sync2[2] & r_reg.tck_q;
   assign tms_s = r_reg.sync2[1];
   assign tdi_s = r_reg.sync2[0];

   // next state of the whole block
   always_comb
   begin
      r_next = r_reg;
      r_next.sync1 = {TCK_I, TMS_I, TDI_I};
      r_next.sync2 = r_reg.sync1;
      r_next.tck_q = r_reg.sync2[2];

      // software write, applied before the link so link events win
      if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid)
      begin
         r_next.bvalid = 1'b1;
         r_next.aw_got = 1'b0;
         r_next.w_got = 1'b0;
         r_next.bresp = addr_ok(r_reg.aw_addr) ? `TDL_RESP_OKAY
                                               : `TDL_RESP_SLVERR;
         if (r_reg.w_strb[0])
         begin
            if (r_reg.aw_addr == `TDL_OFS_STAT)
            begin
               r_next.debug_status_pair = r_reg.w_data[1:0];
            end
            if (r_reg.aw_addr == `TDL_OFS_HOLD)
            begin
               r_next.debug_holding_byte = r_reg.w_data[7:0];
            end
            if (r_reg.aw_addr == `TDL_OFS_TAP &&
                r_reg.w_data[`TDL_TAP_RXF_BIT])
            begin
               r_next.rx_flag = 1'b0; // write one to clear
            end
         end
      end
      else if (r_reg.bvalid && S_AXI_BREADY_I)
      begin
         r_next.bvalid = 1'b0;
      end
      if (S_AXI_AWVALID_I && r_reg.awready)
      begin
         r_next.aw_got = 1'b1;
         r_next.aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && r_reg.wready)
      begin
         r_next.w_got = 1'b1;
         r_next.w_data = S_AXI_WDATA_I;
         r_next.w_strb = S_AXI_WSTRB_I;
      end

      // read channel
      if (r_reg.rvalid && S_AXI_RREADY_I)
      begin
         r_next.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID_I && r_reg.arready)
      begin
         r_next.rvalid = 1'b1;
         r_next.rdata = reg_read(r_reg, S_AXI_ARADDR_I);
         r_next.rresp = addr_ok(S_AXI_ARADDR_I) ? `TDL_RESP_OKAY
                                                : `TDL_RESP_SLVERR;
      end

      // rising test clock: capture and shift, then move on
      if (tck_rise)
      begin
         unique case (r_reg.tap)
            TAP_CAP_IR: r_next.ir_shift = `TDL_IR_CAPTURE;
            TAP_SH_IR: r_next.ir_shift = {tdi_s, r_reg.ir_shift[2:1]};
            TAP_CAP_DR: r_next.byp = 1'b0;
            TAP_SH_DR:
            begin
               // only the selected register moves; lsb leaves first
               unique case (r_reg.sel)
                  SEL_BYP: r_next.byp = tdi_s;
                  SEL_DBG: r_next.dsr = {tdi_s, r_reg.dsr[9:1]};
                  SEL_PRG: r_next.psr = {tdi_s, r_reg.psr[2:1]};
                  default: r_next.byp = tdi_s;
               endcase
            end
            default: r_next.tap = r_reg.tap;
         endcase
         r_next.tap = tap_step(r_reg.tap, tms_s);
         // run of rising edges with mode select high
         r_next.tms_run = !tms_s ? 3'h0 :
            (r_reg.tms_run == 3'h7 ? 3'h7 : r_reg.tms_run + 3'h1);
      end

      // falling test clock: update and drive serial output
      if (tck_fall)
      begin
         if (r_reg.tap == TAP_UPD_IR)
         begin
            r_next.instr_parallel_reg = r_reg.ir_shift;
            r_next.sel = sel_decode(r_reg.ir_shift, r_reg.sel);
         end
         if (r_reg.tap == TAP_UPD_DR && r_reg.sel == SEL_DBG)
         begin
            // status pair low, byte above it
            r_next.debug_holding_byte = r_reg.dsr[9:2];
            r_next.dsr = {r_reg.debug_holding_byte,
                          r_reg.debug_status_pair};
            r_next.rx_flag = 1'b1;
         end
         if (r_reg.tap == TAP_UPD_DR && r_reg.sel == SEL_PRG)
         begin
            r_next.prg_par = r_reg.psr;
            r_next.psr = r_reg.prg_par;
         end
         r_next.tdo_oe = (r_reg.tap == TAP_SH_IR || r_reg.tap == TAP_SH_DR);
         if (r_reg.tap == TAP_SH_IR)
         begin
            r_next.tdo = r_reg.ir_shift[0];
         end
         else if (r_reg.tap == TAP_SH_DR)
         begin
            unique case (r_reg.sel)
               SEL_DBG: r_next.tdo = r_reg.dsr[0];
               SEL_PRG: r_next.tdo = r_reg.psr[0];
               default: r_next.tdo = r_reg.byp;
            endcase
         end
      end

      // reset state forces bypass; otherwise instruction is kept
      if (r_next.tap == TAP_TLR)
      begin
         r_next.instr_parallel_reg = `TDL_IR_BYPASS;
         r_next.sel = SEL_BYP;
      end

      // handshake readies follow the pending state
      r_next.awready = !r_next.aw_got && !r_next.bvalid;
      r_next.wready = !r_next.w_got && !r_next.bvalid;
      r_next.arready = !r_next.rvalid;
   end

   // state register; reset enters the reset state with bypass
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         r_reg <= '0;
         r_reg.tap <= TAP_TLR;
         r_reg.instr_parallel_reg <= `TDL_IR_BYPASS;
         r_reg.sel <= SEL_BYP;
         r_reg.debug_status_pair <= `TDL_RST_STAT;
         r_reg.debug_holding_byte <= `TDL_RST_HOLD;
         r_reg.awready <= 1'b1;
         r_reg.wready <= 1'b1;
         r_reg.arready <= 1'b1;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // outputs straight from the state register
   assign TDO_O = r_reg.tdo;
   assign TDO_OE_O = r_reg.tdo_oe;
   assign S_AXI_AWREADY_O = r_reg.awready;
   assign S_AXI_WREADY_O = r_reg.wready;
   assign S_AXI_BVALID_O = r_reg.bvalid;
   assign S_AXI_BRESP_O = r_reg.bresp;
   assign S_AXI_ARREADY_O = r_reg.arready;
   assign S_AXI_RVALID_O = r_reg.rvalid;
   assign S_AXI_RDATA_O = r_reg.rdata;
   assign S_AXI_RRESP_O = r_reg.rresp;

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_upd_ir_fall;
      tck_fall && r_reg.tap == TAP_UPD_IR;
   endsequence
   sequence s_upd_dbg_fall;
      tck_fall && r_reg.tap == TAP_UPD_DR && r_reg.sel == SEL_DBG;
   endsequence

   property p_tlr_bypass;
      r_reg.tap == TAP_TLR |->
         r_reg.instr_parallel_reg == `TDL_IR_BYPASS && r_reg.sel == SEL_BYP;
   endproperty
   a_tlr_bypass: assert property (p_tlr_bypass)
      else $error("reset state without bypass instruction");
   property p_five_high;
      r_reg.tms_run >= 3'h5 |-> r_reg.tap == TAP_TLR;
   endproperty
   a_five_high: assert property (p_five_high)
      else $error("five high mode selects did not reach reset state");

   property p_tlr_stay;
      tck_rise && tms_s && r_reg.tap == TAP_TLR |=> r_reg.tap == TAP_TLR;
   endproperty
   a_tlr_stay: assert property (p_tlr_stay)
      else $error("left reset state with mode select high");

   property p_hold_low;
      !tck_rise && !tck_fall |=> $stable(r_reg.tap) &&
         $stable(r_reg.ir_shift) && $stable(r_reg.dsr) &&
         $stable(r_reg.psr) && $stable(r_reg.byp);
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("scan state moved without a test clock edge");

   property p_cap_ir;
      tck_rise && r_reg.tap == TAP_CAP_IR |=>
         r_reg.ir_shift == `TDL_IR_CAPTURE;
   endproperty
   a_cap_ir: assert property (p_cap_ir)
      else $error("capture-ir did not load fixed pattern");

   property p_upd_ir;
      s_upd_ir_fall |=> r_reg.instr_parallel_reg == $past(r_reg.ir_shift);
   endproperty
   a_upd_ir: assert property (p_upd_ir)
      else $error("update-ir did not latch instruction");

   property p_nop_keep;
      s_upd_ir_fall ##0 r_reg.ir_shift[2:1] == 2'b00 |=> $stable(r_reg.sel);
   endproperty
   a_nop_keep: assert property (p_nop_keep)
      else $error("no-operation code changed the data path");

   property p_dr_no_ir;
      r_reg.tap inside {TAP_CAP_DR, TAP_SH_DR, TAP_UPD_DR} &&
         r_next.tap != TAP_TLR |=>
         $stable(r_reg.instr_parallel_reg) && $stable(r_reg.ir_shift);
   endproperty
   a_dr_no_ir: assert property (p_dr_no_ir)
      else $error("data scan altered instruction registers");

   property p_dbg_update;
      s_upd_dbg_fall |=> r_reg.debug_holding_byte == $past(r_reg.dsr[9:2])
         && r_reg.dsr[1:0] == $past(r_reg.debug_status_pair);
   endproperty
   a_dbg_update: assert property (p_dbg_update)
      else $error("debug update did not exchange holding byte");

   property p_tdo_fall;
      tck_fall && r_reg.tap == TAP_SH_DR && r_reg.sel == SEL_DBG |=>
         r_reg.tdo == $past(r_reg.dsr[0]) && r_reg.tdo_oe;
   endproperty
   a_tdo_fall: assert property (p_tdo_fall)
      else $error("serial output not the debug lsb");

endmodule

//--- dv/tdl_host_model.sv
// host side model of the test port: drives test clock, mode and data
`timescale 1ns/100ps
module tdl_host_model (
   input wire logic clk_i,
   input wire logic tdo_i,
   input wire logic tdo_oe_i,
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o
);
   int half = 8; // system clocks per test clock phase

   // test clock stands low between frames, data line idles high
   initial
   begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
   end

   // one test clock period; output line is taken at the rise
   task automatic step(input logic m, input logic d, output logic q);
      @(posedge clk_i);
      tms_o <= m;
      tdi_o <= d;
      repeat (half) @(posedge clk_i);
      tck_o <= 1'b1;
      q = tdo_oe_i ? tdo_i : 1'b1; // released line floats up
      repeat (half) @(posedge clk_i);
      tck_o <= 1'b0;
      tdi_o <= 1'b1;
   endtask

   // walk to a shift state, move n bits, update, return to idle
   task automatic scan(input logic ir, input int n, input logic [9:0] din,
                       output logic [9:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      if (ir)
         step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q); // capture
      step(1'b0, 1'b1, q); // enter shift
      // low bit first: status pair leads, then the byte
      for (int i = 0; i < n; i++)
         step(i == n - 1, din[i], dout[i]);
      step(1'b1, 1'b1, q); // update
      step(1'b0, 1'b1, q);
   endtask
endmodule

//--- dv/testbench.sv
// self-checking bench for the test port and debug link block
`timescale 1ns/100ps
`include "tdl_cfg.svh"
module testbench;
   import tdl_pkg::*;
   typedef struct packed {
      logic [31:0] mask;
      logic [1:0] resp;
      logic [31:0] data;
   } tdl_exp_t;
   localparam logic [7:0] A_ST = `TDL_OFS_STAT;
   localparam logic [7:0] A_HD = `TDL_OFS_HOLD;
   localparam logic [7:0] A_TP = `TDL_OFS_TAP;
   localparam logic [1:0] OK = `TDL_RESP_OKAY;
   localparam logic [1:0] SE = `TDL_RESP_SLVERR;
   localparam logic [31:0] MA = 32'hFFFFFFFF;
   localparam logic [31:0] MS = 32'h0000307F;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   int seed = 6112;
   int k;
   tdl_exp_t rq[$];
   logic [1:0] bq[$];
   tdl_exp_t e;
   logic [9:0] o, w, v, p;
   logic [7:0] h;

   // 200 MHz system clock
   always #2.5 sys_clk = ~sys_clk;

   tdl_top uut (
      .SYS_CLK_I(sys_clk),
      .RST_N_I(rst_n),
      .TCK_I(tck),
      .TMS_I(tms),
      .TDI_I(tdi),
      .TDO_O(tdo),
      .TDO_OE_O(tdo_oe),
      .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awvalid),
      .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb),
      .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr),
      .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready)
   );

   tdl_host_model host (
      .clk_i(sys_clk),
      .tdo_i(tdo),
      .tdo_oe_i(tdo_oe),
      .tck_o(tck),
      .tms_o(tms),
      .tdi_o(tdi)
   );

   task automatic finish_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: bus %h, want %h", $time, got, exp);
      end
   endtask

   task automatic chk_scan(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: scan %h, want %h", $time, got, exp);
      end
   endtask

   // bus write; the response code is noted for the watcher
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s, input logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      bq.push_back(r);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (aw_ok && w_ok && bvalid)
         begin
            bready <= 1'b0;
            break;
         end
         if (!aw_ok && awready)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
   endtask

   // bus read; expected word, mask and code are noted for the watcher
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                         input logic [31:0] m, input logic [1:0] r);
      logic ar_ok;
      ar_ok = 1'b0;
      rq.push_back('{m, r, d});
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge sys_clk);
         if (ar_ok && rvalid)
         begin
            rready <= 1'b0;
            break;
         end
         if (!ar_ok && arready)
         begin
            ar_ok = 1'b1;
            arvalid <= 1'b0;
         end
      end
   endtask

   // read of the port status word built from its fields
   task automatic rd_tap(input logic [3:0] st, input logic [2:0] ins,
                         input logic rx, input logic [2:0] pg,
                         input logic [1:0] sl, input logic [31:0] m);
      axi_rd(A_TP, {18'h0, sl, 1'b0, pg, rx, ins, st}, m, OK);
   endtask

   // watcher: each finished bus answer against the oldest note
   always @(posedge sys_clk)
   begin
      if (rvalid && rready)
      begin
         e = rq.pop_front();
         chk_bus({rresp, rdata & e.mask}, {e.resp, e.data});
      end
      if (bvalid && bready)
         chk_bus({bresp, 32'h0}, {bq.pop_front(), 32'h0});
   end

   // hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         miscompares++;
         finish_test();
      end
   end

   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      // reset values, an unmapped place, a write with byte 0 off
      axi_rd(A_ST, 32'h0, MA, OK);
      axi_rd(A_HD, 32'h0, MA, OK);
      rd_tap(TAP_TLR, `TDL_IR_BYPASS, 1'b0, 3'h0, SEL_BYP, MS);
      axi_rd(8'h0C, 32'h0, MA, SE);
      axi_wr(8'h10, 32'h5A, 4'hF, SE);
      axi_wr(A_HD, 32'h5A, 4'hE, OK);
      axi_rd(A_HD, 32'h0, MA, OK);
      host.step(1'b0, 1'b1, o[0]); // leave the reset state for idle
      // the three bypass codes
      for (k = 3; k < 8; k += 2)
      begin
         host.scan(1'b1, 3, 10'(k), o);
         chk_scan(o, 10'h001);
         rd_tap(TAP_RTI, 3'(k), 1'b0, 3'h0, SEL_BYP, MS);
         w = 10'($random(seed));
         host.scan(1'b0, 5, w, o);
         chk_scan(o, {5'h0, w[3:0], 1'b0});
      end
      // stall with the test clock low inside shift
      host.step(1'b1, 1'b1, o[0]);
      host.step(1'b0, 1'b1, o[0]);
      host.step(1'b0, 1'b1, o[0]);
      rd_tap(TAP_SH_DR, 3'h0, 1'b0, 3'h0, SEL_BYP, 32'hF);
      repeat (64) @(posedge sys_clk);
      rd_tap(TAP_SH_DR, 3'h0, 1'b0, 3'h0, SEL_BYP, 32'hF);
      host.step(1'b1, 1'b1, o[0]);
      host.step(1'b1, 1'b1, o[0]);
      host.step(1'b0, 1'b1, o[0]);
      // debug link with a slower host
      host.half = 12;
      host.scan(1'b1, 3, 10'(`TDL_IR_DEBUG), o);
      rd_tap(TAP_RTI, `TDL_IR_DEBUG, 1'b0, 3'h0, SEL_DBG, MS);
      for (k = 0; k < 4; k++)
      begin
         h = 8'($random(seed));
         axi_wr(A_ST, 32'(k), 4'hF, OK);
         axi_wr(A_HD, {24'h0, h}, 4'hF, OK);
         w = 10'($random(seed));
         host.scan(1'b0, 10, w, o);
         axi_rd(A_HD, {24'h0, w[9:2]}, MA, OK);
         rd_tap(TAP_RTI, `TDL_IR_DEBUG, 1'b1, 3'h0, SEL_DBG, 32'h30FF);
         v = 10'($random(seed));
         host.scan(1'b0, 10, v, o);
         chk_scan(o, {h, 2'(k)});
      end
      // writing one to the flag bit clears it
      axi_wr(A_TP, 32'h80, 4'hF, OK);
      rd_tap(TAP_RTI, `TDL_IR_DEBUG, 1'b0, 3'h0, SEL_DBG, 32'h30FF);
      host.half = 8;
      // the no-operation codes keep the debug path
      p = {w[9:2], 2'h3};
      h = v[9:2];
      for (k = 0; k < 2; k++)
      begin
         host.scan(1'b1, 3, 10'(k), o);
         w = 10'($random(seed));
         host.scan(1'b0, 10, w, o);
         chk_scan(o, p);
         rd_tap(TAP_RTI, 3'(k), 1'b0, 3'h0, SEL_DBG, MS);
         p = {h, 2'h3};
         h = w[9:2];
      end
      // programming path
      host.scan(1'b1, 3, 10'(`TDL_IR_PROG), o);
      rd_tap(TAP_RTI, `TDL_IR_PROG, 1'b0, 3'h0, SEL_PRG, MS);
      w = 10'($random(seed));
      host.scan(1'b0, 3, w, o);
      rd_tap(TAP_RTI, `TDL_IR_PROG, 1'b0, w[2:0], SEL_PRG, 32'h377F);
      v = 10'($random(seed));
      host.scan(1'b0, 3, v, o);
      host.scan(1'b0, 3, v, o);
      chk_scan(o, {7'h0, w[2:0]});
      // mode select high: reset state and bypass come back
      repeat (5) host.step(1'b1, 1'b1, o[0]);
      rd_tap(TAP_TLR, `TDL_IR_BYPASS, 1'b0, 3'h0, SEL_BYP, MS);
      repeat (2) @(posedge sys_clk); // let the watcher take the last answer
      finish_test();
   end
endmodule
